/* gdio_regs.vh */
`ifndef GDIO_REGS_VH
`define GDIO_REGS_VH

// Register byte addresses
`define GDIO_ADDR_INPUT     12'h000
`define GDIO_ADDR_DIR       12'h004
`define GDIO_ADDR_OUTVAL    12'h008
`define GDIO_ADDR_MCUCTRL   12'h00C
`define GDIO_ADDR_IRQSTAT   12'h010
`define GDIO_ADDR_IRQMASK   12'h014
`define GDIO_ADDR_EXTINTEN  12'h018
`define GDIO_ADDR_EXTSENSE  12'h01C

// Field position and field width
`define GDIO_MCUCTRL_PUD    0
`define GDIO_SENSE_W        2

// Sense codes per pin
`define GDIO_SENSE_LEVEL    2'h0
`define GDIO_SENSE_ANY      2'h1
`define GDIO_SENSE_FALL     2'h2
`define GDIO_SENSE_RISE     2'h3

// Reset values
`define GDIO_RST_ZERO       32'h0000_0000

`endif

/* gdio_sync_cell.v */
`timescale 1ns/1ns
`default_nettype none

module gdio_sync_cell
#(
   parameter WIDTH = 8
)
(
   input  wire             core_clk,   // System clock
   input  wire             ce,         // Clock enable
   input  wire [WIDTH-1:0] padIn,      // Clamped pad levels
   output reg  [WIDTH-1:0] syncOut_ff  // Synchronised levels
);

   reg [WIDTH-1:0] latchVal;

   // ***************************************************
   // Latch open while clock high, flop on rising edge
   // ***************************************************
   // Held value is what the open latch shows as the clock falls;
   // capturing it there keeps the rising-edge flop free of a race
   always @(negedge core_clk)
   begin
      if (ce)
         latchVal <= padIn;
   end

   always @(posedge core_clk)
   begin
      if (ce)
         syncOut_ff <= latchVal;
   end

endmodule

`default_nettype wire

/* gdio_port.v */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gdio_regs.vh"

module gdio_port
#(
   parameter WIDTH = 8
)
(
   input  wire             core_clk,    // System clock, 100 MHz
   input  wire             rst,         // Sync reset, active high
   input  wire             ce,          // Clock enable
   input  wire             psel,        // APB select
   input  wire             penable,     // APB enable
   input  wire             pwrite,      // APB direction
   input  wire [11:0]      paddr,       // APB byte address
   input  wire [31:0]      pwdata,      // APB write data
   output reg  [31:0]      prdata,      // APB read data
   output reg              pready,      // APB ready
   output reg              pslverr,     // APB error
   input  wire [WIDTH-1:0] padIn,       // Pad levels
   output reg  [WIDTH-1:0] padOut,      // Pad drive value
   output reg  [WIDTH-1:0] padOe,       // Pad drive enable
   output reg  [WIDTH-1:0] pullUpEn,    // Pull-up enable
   input  wire             sleepClamp,  // Deep sleep clamp request
   output reg              irq          // Level interrupt
);

   // ***************************************************
   // State
   // ***************************************************
   reg  [WIDTH-1:0] dirBits_ff;
   reg  [WIDTH-1:0] outVal_ff;
   reg              pud_ff;
   reg  [WIDTH-1:0] irqStat_ff;
   reg  [WIDTH-1:0] irqMask_ff;
   reg  [WIDTH-1:0] extIntEn_ff;
   reg  [2*WIDTH-1:0] sense_ff;
   reg  [WIDTH-1:0] prevIn_ff;
   reg  [WIDTH-1:0] nxt_outVal;
   reg  [WIDTH-1:0] nxt_irqStat;
   reg  [WIDTH-1:0] edgeHit;
   reg  [31:0]      rdMux;
   reg              rdHit;
   wire [WIDTH-1:0] clampedIn;
   wire [WIDTH-1:0] pinIn;
   wire             wrAcc;
   wire             rdAcc;
   wire             setup;
   wire [WIDTH-1:0] wdat;
   wire [WIDTH-1:0] toggleMask;

   assign setup = psel && !penable;
   assign wrAcc = psel && penable && pready && pwrite;
   assign rdAcc = psel && penable && pready && !pwrite;
   assign wdat  = pwdata[WIDTH-1:0];
   assign toggleMask = (wrAcc && paddr == `GDIO_ADDR_INPUT) ?
                       wdat : {WIDTH{1'b0}};

   // ***************************************************
   // Input clamp and synchroniser
   // ***************************************************
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1)
      begin : gClamp
         assign clampedIn[gi] = padIn[gi] &
                                (~sleepClamp | extIntEn_ff[gi]);
      end
   endgenerate

   gdio_sync_cell #(.WIDTH(WIDTH)) uSync
   (
      .core_clk (core_clk),
      .ce       (ce),
      .padIn    (clampedIn),
      .syncOut_ff (pinIn)
   );

   // ***************************************************
   // Pad drive, asynchronous reset gating
   // ***************************************************
   // Reset masks drive and pull-up directly so no clock is needed
   always @*
   begin
      padOe    = rst ? {WIDTH{1'b0}} : dirBits_ff;
      padOut   = rst ? {WIDTH{1'b0}} : outVal_ff;
      pullUpEn = rst ? {WIDTH{1'b0}} :
                 (~dirBits_ff & outVal_ff &
                  {WIDTH{~pud_ff}});
   end

   // ***************************************************
   // Next-state logic
   // ***************************************************
   integer k;
   always @*
   begin
      nxt_outVal = outVal_ff ^ toggleMask;
      if (wrAcc && paddr == `GDIO_ADDR_OUTVAL)
         nxt_outVal = wdat;
      for (k = 0; k < WIDTH; k = k + 1)
      begin
         case (sense_ff[2*k +: `GDIO_SENSE_W])
            `GDIO_SENSE_ANY:  edgeHit[k] = pinIn[k] ^ prevIn_ff[k];
            `GDIO_SENSE_FALL: edgeHit[k] = ~pinIn[k] & prevIn_ff[k];
            `GDIO_SENSE_RISE: edgeHit[k] = pinIn[k] & ~prevIn_ff[k];
            default:          edgeHit[k] = 1'b0;
         endcase
      end
      nxt_irqStat = irqStat_ff;
      if (wrAcc && paddr == `GDIO_ADDR_IRQSTAT)
         nxt_irqStat = irqStat_ff & ~wdat;
      // Set wins over clear; disabled pins still flag
      nxt_irqStat = nxt_irqStat | edgeHit;
   end

   // ***************************************************
   // Read mux
   // ***************************************************
   always @*
   begin
      rdMux = `GDIO_RST_ZERO;
      rdHit = 1'b1;
      case (paddr)
         `GDIO_ADDR_INPUT:    rdMux[WIDTH-1:0] = pinIn;
         `GDIO_ADDR_DIR:      rdMux[WIDTH-1:0] = dirBits_ff;
         `GDIO_ADDR_OUTVAL:   rdMux[WIDTH-1:0] = outVal_ff;
         `GDIO_ADDR_MCUCTRL:  rdMux[`GDIO_MCUCTRL_PUD] = pud_ff;
         `GDIO_ADDR_IRQSTAT:  rdMux[WIDTH-1:0] = irqStat_ff;
         `GDIO_ADDR_IRQMASK:  rdMux[WIDTH-1:0] = irqMask_ff;
         `GDIO_ADDR_EXTINTEN: rdMux[WIDTH-1:0] = extIntEn_ff;
         `GDIO_ADDR_EXTSENSE: rdMux[2*WIDTH-1:0] = sense_ff;
         default:             rdHit = 1'b0;
      endcase
   end

   // ***************************************************
   // Registers
   // ***************************************************
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         dirBits_ff  <= {WIDTH{1'b0}};
         outVal_ff   <= {WIDTH{1'b0}};
         pud_ff      <= 1'b0;
         irqStat_ff  <= {WIDTH{1'b0}};
         irqMask_ff  <= {WIDTH{1'b0}};
         extIntEn_ff <= {WIDTH{1'b0}};
         sense_ff    <= {2*WIDTH{1'b0}};
         prevIn_ff   <= {WIDTH{1'b0}};
         prdata      <= `GDIO_RST_ZERO;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         irq         <= 1'b0;
      end
      else if (ce)
      begin
         pready     <= setup;
         pslverr    <= setup && !rdHit;
         prdata     <= (setup && !pwrite) ? rdMux : `GDIO_RST_ZERO;
         prevIn_ff  <= pinIn;
         outVal_ff  <= nxt_outVal;
         irqStat_ff <= nxt_irqStat;
         irq        <= |(nxt_irqStat & irqMask_ff);
         if (wrAcc && paddr == `GDIO_ADDR_DIR)
            dirBits_ff <= wdat;
         if (wrAcc && paddr == `GDIO_ADDR_MCUCTRL)
            pud_ff <= pwdata[`GDIO_MCUCTRL_PUD];
         if (wrAcc && paddr == `GDIO_ADDR_IRQMASK)
            irqMask_ff <= wdat;
         if (wrAcc && paddr == `GDIO_ADDR_EXTINTEN)
            extIntEn_ff <= wdat;
         if (wrAcc && paddr == `GDIO_ADDR_EXTSENSE)
            sense_ff <= pwdata[2*WIDTH-1:0];
      end
   end

endmodule

`default_nettype wire

/* gdio_port_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module gdio_port_checker
#(
   parameter WIDTH = 8
)
(
   input wire logic             core_clk, // Clock
   input wire logic             rst,      // Reset
   input wire logic             psel,     // Select
   input wire logic             penable,  // Enable
   input wire logic             pwrite,   // Write
   input wire logic [11:0]      paddr,    // Address
   input wire logic [31:0]      pwdata,   // Data
   input wire logic             pready,   // Ready
   input wire logic [WIDTH-1:0] padOut,   // Drive
   input wire logic [WIDTH-1:0] padOe,    // Enable
   input wire logic [WIDTH-1:0] pullUpEn  // Pull-up
);
   wire logic [WIDTH-1:0] wLow = pwdata[WIDTH-1:0];
   wire logic             wDone = psel & penable & pready & pwrite;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_rst; disable iff (1'b0) rst |-> (padOe | pullUpEn) == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("pin active in reset");
   property p_rel; $fell(rst) |-> padOe == '0 && pullUpEn == '0;
   endproperty
   a_rel: assert property (p_rel) else $error("pin active at start");
   property p_dir; wDone && paddr == 12'h004 |=> padOe == $past(wLow);
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_drv; wDone && paddr == 12'h008 |=> (padOut & padOe) ==
      ($past(wLow) & padOe); endproperty
   a_drv: assert property (p_drv) else $error("drive wrong");
   property p_tgl; wDone && paddr == 12'h000 |=>
      ((padOut ^ $past(padOut)) & padOe) == ($past(wLow) & padOe); endproperty
   a_tgl: assert property (p_tgl) else $error("toggle wrong");
   property p_pud; wDone && paddr == 12'h00C && pwdata[0] |=> !pullUpEn;
   endproperty
   a_pud: assert property (p_pud) else $error("pull-up not off");
   property p_pu; (pullUpEn & padOe) == '0; endproperty
   a_pu: assert property (p_pu) else $error("pull-up on output");
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
endmodule
bind gdio_port gdio_port_checker #(.WIDTH(WIDTH)) i_gdio_port_checker
   (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn));
`default_nettype wire

/* gdio_pad_model.sv */
`timescale 1ns/1ns
`default_nettype none
module gdio_pad_model
(
   input  wire logic       core_clk, // Clock
   input  wire logic [7:0] padOut,   // Port drive
   input  wire logic [7:0] padOe,    // Port enable
   input  wire logic [7:0] pullUpEn, // Port pull-up
   input  wire logic [7:0] extVal,   // Outside value
   input  wire logic [7:0] extEn,    // Outside enable
   output wire logic [7:0] padIn     // Pad level
);
   logic [7:0] noise_ff = 8'h00;
   // Undriven pads wander
   always @(posedge core_clk) noise_ff <= ~noise_ff;
   assign padIn = padOe & padOut | ~padOe & extEn & extVal
                | ~padOe & ~extEn & (pullUpEn | noise_ff);
endmodule
`default_nettype wire

/* gdio_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gdio_regs.vh"
module gdio_port_tb_top;
   logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, sleepClamp = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, lfsr = 32'h0001_4AD4;
   logic [7:0]  extVal = 8'h00, extEn = 8'h00, r1, r2, r3;
   wire logic [31:0] prdata;
   wire logic [7:0]  padIn, padOut, padOe, pullUpEn;
   wire logic        pready, pslverr, irq;
   logic [32:0] expQ[$];
   int          nFail = 0, checksDone = 0;
   initial forever #5 core_clk = ~core_clk;
   gdio_port i_gdio_port (.core_clk(core_clk), .rst(rst), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn),
      .sleepClamp(sleepClamp), .irq(irq));
   gdio_pad_model i_gdio_pad_model (.core_clk(core_clk), .padOut(padOut),
      .padOe(padOe), .pullUpEn(pullUpEn), .extVal(extVal), .extEn(extEn),
      .padIn(padIn));
   task automatic chk(input string n, input logic [32:0] e, g);
      checksDone++;
      if (g !== e)
      begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      expQ.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic closeOut();
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Read results, oldest note first
   always @(posedge core_clk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("read", expQ.pop_front(), {pslverr, prdata});
   initial
   begin
      repeat (4) @(posedge core_clk);
      chk("reset pins", 8'h00, padOe | pullUpEn);
      rst <= 1'b0;
      rd(`GDIO_ADDR_DIR, 33'h0_0000_0000);
      rd(12'h020, 33'h1_0000_0000);
      $display("reset test done");
      for (int i = 0; i < 6; i++)
      begin
         lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         {r3, r2, r1} = lfsr[23:0];
         wr(`GDIO_ADDR_OUTVAL, r1);
         wr(`GDIO_ADDR_DIR, r2);
         extEn <= ~r2;
         extVal <= r3;
         @(negedge core_clk);
         chk("oe", r2, padOe);
         chk("drive", r1 & r2, padOut & padOe);
         chk("pull-up", r1 & ~r2, pullUpEn);
         rd(`GDIO_ADDR_OUTVAL, r1);
         wr(`GDIO_ADDR_INPUT, r3);
         r1 = r1 ^ r3;
         rd(`GDIO_ADDR_INPUT, r1 & r2 | r3 & ~r2);
      end
      $display("pin test done");
      wr(`GDIO_ADDR_MCUCTRL, 32'h0000_0001);
      @(negedge core_clk);
      chk("global off", 8'h00, pullUpEn);
      wr(`GDIO_ADDR_MCUCTRL, 32'h0000_0000);
      rst <= 1'b1;
      @(negedge core_clk);
      chk("reset pull-up", 8'h00, pullUpEn | padOe);
      @(posedge core_clk);
      rst <= 1'b0;
      extEn <= 8'hFF;
      extVal <= 8'h01;
      $display("pull-up test done");
      wr(`GDIO_ADDR_EXTSENSE, 32'h0000_0003);
      wr(`GDIO_ADDR_IRQMASK, 32'h0000_0001);
      sleepClamp <= 1'b1;
      rd(`GDIO_ADDR_INPUT, 33'h0_0000_0000);
      sleepClamp <= 1'b0;
      for (int t = 0; t < 20 && irq !== 1'b1; t++) @(posedge core_clk);
      rd(`GDIO_ADDR_IRQSTAT, 33'h0_0000_0001);
      chk("irq set", 1'b1, irq);
      wr(`GDIO_ADDR_IRQMASK, 32'h0000_0000);
      repeat (2) @(negedge core_clk);
      chk("irq masked", 1'b0, irq);
      wr(`GDIO_ADDR_IRQMASK, 32'h0000_0001);
      wr(`GDIO_ADDR_IRQSTAT, 32'h0000_0001);
      repeat (2) @(negedge core_clk);
      chk("irq cleared", 1'b0, irq);
      wr(`GDIO_ADDR_EXTINTEN, 32'h0000_0001);
      sleepClamp <= 1'b1;
      rd(`GDIO_ADDR_INPUT, 33'h0_0000_0001);
      $display("interrupt test done");
      closeOut();
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      nFail++;
      closeOut();
   end
endmodule
`default_nettype wire
